// file: afrp_core.sv
package afrp_pkg;
  localparam int             SAMPLE_W  = 20;
  localparam int             WORD_W    = 18;
  localparam int             SUM_W     = 25;
  localparam int             DEC_LOG2  = 5;
  localparam int             PTR_W     = 4;
  localparam int             MEM_DEPTH = 16;
  localparam int             LVL_W     = 3;
  localparam int             GAP_W     = 9;
  localparam int             REL_W     = 10;
  localparam logic [4:0]     DEC_LAST  = 5'h1F;
  localparam logic [4:0]     DEC_PRE   = 5'h1E;
  localparam logic [4:0]     DEC_HALF  = 5'h0F;
  localparam logic [4:0]     DEC_ZERO  = 5'h00;
  localparam logic [2:0]     LVL_OFF   = 3'h0;
  localparam logic [2:0]     LVL_ONE   = 3'h1;
  localparam logic [SAMPLE_W-1:0] POS_LIM = 20'h1FFFF;
  localparam logic [SAMPLE_W-1:0] NEG_LIM = 20'hE0000;
  localparam logic [WORD_W-1:0]   POS_FULL = 18'h1FFFF;
  localparam logic [WORD_W-1:0]   NEG_FULL = 18'h20000;
  localparam logic [WORD_W-1:0]   WORD_RST = 18'h00000;

  // readout pins from the host
  typedef struct packed {
    logic rd_n;
    logic cs_n;
  } afrp_host_type;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_FILL   = 2'b01,
    ST_RUN    = 2'b10
  } afrp_state_type;
endpackage

`timescale 1ns/1ps
module afrp_core import afrp_pkg::*; (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // modulator samples, one per clock
  input  wire logic signed [SAMPLE_W-1:0] sample_i,
  // host pins
  input  wire afrp_host_type              host_i,
  input  wire logic [LVL_W-1:0]           buffer_depth_sel_i,
  // outputs
  output logic                            sample_ready_n_o,
  output logic                            over_range_flag_o,
  output logic [WORD_W-1:0]               dout_o,
  output logic                            dout_oe_o
);
  // pin synchronisers
  afrp_host_type    host_m, host_s;
  logic [LVL_W-1:0] sel_m, sel_s;
  logic             rd_prev;

  // decimator
  logic [4:0]             dec_cnt, next_dec_cnt;
  logic signed [SUM_W-1:0] acc, next_acc;
  logic signed [SUM_W-1:0] sum_all;
  logic signed [SAMPLE_W-1:0] avg;
  logic [WORD_W-1:0]      word;
  logic                   clip;
  logic                   tick;
  logic                   over, next_over;

  // grouping and readout
  afrp_state_type   state, next_state;
  logic [LVL_W-1:0] lvl, next_lvl, sel_eff;
  logic [LVL_W-1:0] widx, next_widx;
  logic             sample_ready_n, next_sample_ready_n;
  logic             group_done;
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic             wr_en;
  logic             rd_rise;
  logic [WORD_W-1:0] rd_data, next_dout;
  logic             next_oe;

  // two flops on every host pin and the depth select before any logic; sample_i is used unsynchronised
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_m  <= '1;
      host_s  <= '1;
      sel_m   <= LVL_OFF;
      sel_s   <= LVL_OFF;
      rd_prev <= 1'b1;
    end else begin
      host_m  <= host_i;
      host_s  <= host_m;
      sel_m   <= buffer_depth_sel_i;
      sel_s   <= sel_m;
      rd_prev <= host_s.rd_n || host_s.cs_n;  // low only while a selected read is held
    end
  end

  // accumulate one sample per clock, dump every 32
  always_comb begin
    tick         = (dec_cnt == DEC_LAST);
    next_dec_cnt = dec_cnt + 5'h01;
    sum_all      = acc + SUM_W'(sample_i);
    next_acc     = tick ? '0 : sum_all;
    avg          = sum_all[SUM_W-1:DEC_LOG2];
    clip         = (avg > $signed(POS_LIM)) || (avg < $signed(NEG_LIM));
    if (avg > $signed(POS_LIM)) begin
      word = POS_FULL;
    end else if (avg < $signed(NEG_LIM)) begin
      word = NEG_FULL;
    end else begin
      word = avg[WORD_W-1:0];
    end
    next_over = tick ? clip : over;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_cnt <= DEC_ZERO;
      acc     <= '0;
      over    <= 1'b0;
    end else begin
      dec_cnt <= next_dec_cnt;
      acc     <= next_acc;
      over    <= next_over;
    end
  end

  // group sequencing, strobe and pointers
  always_comb begin
    sel_eff     = (sel_s == LVL_OFF) ? LVL_ONE : sel_s;
    group_done  = tick && (state != ST_SETTLE) && (widx == lvl - LVL_ONE);
    wr_en       = tick && (state != ST_SETTLE);
    rd_rise     = host_s.rd_n && !rd_prev;                                  // select may rise with read
    next_state  = state;
    next_lvl    = lvl;
    next_widx   = widx;
    next_wr_ptr = wr_en ? wr_ptr + 4'h1 : wr_ptr;
    next_rd_ptr = rd_rise ? rd_ptr + 4'h1 : rd_ptr;
    next_sample_ready_n   = sample_ready_n;
    case (state)
      ST_SETTLE: begin
        next_sample_ready_n = 1'b1;
        if (tick) begin
          next_state = ST_FILL;                                             // first word discarded
          next_lvl   = sel_eff;
          next_widx  = '0;
        end
      end
      ST_FILL, ST_RUN: begin
        if (group_done) begin
          next_state  = ST_RUN;
          next_lvl    = sel_eff;
          next_widx   = '0;
          next_sample_ready_n   = 1'b0;
          next_rd_ptr = next_wr_ptr - PTR_W'(lvl);                          // oldest word of the group
        end else begin
          if (tick) begin
            next_widx = widx + LVL_ONE;
          end
          if (state == ST_FILL) begin
            next_sample_ready_n = 1'b1;
          end else if (sel_s == LVL_OFF && lvl == LVL_ONE) begin
            next_sample_ready_n = (dec_cnt >= DEC_HALF);                              // half-period strobe
          end else begin
            next_sample_ready_n = (dec_cnt == DEC_PRE) && (widx == lvl - LVL_ONE);
          end
        end
      end
      default: begin
        next_state = ST_SETTLE;
        next_sample_ready_n  = 1'b1;
      end
    endcase
    next_dout = rd_data;
    next_oe   = !host_s.rd_n && !host_s.cs_n;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= ST_SETTLE;
      lvl    <= LVL_ONE;
      widx   <= '0;
      sample_ready_n   <= 1'b1;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      state  <= next_state;
      lvl    <= next_lvl;
      widx   <= next_widx;
      sample_ready_n   <= next_sample_ready_n;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // output registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_o    <= WORD_RST;
      dout_oe_o <= 1'b0;
    end else begin
      dout_o    <= next_dout;
      dout_oe_o <= next_oe;
    end
  end

  assign sample_ready_n_o  = sample_ready_n;
  assign over_range_flag_o = over;

  afrp_word_store u_store (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_en),
    .wr_ptr_i  (wr_ptr),
    .wr_data_i (word),
    .rd_ptr_i  (rd_ptr),
    .rd_data_o (rd_data)
  );

  // helper counters for the checks
  logic [GAP_W-1:0] gap;
  logic [REL_W-1:0] rel;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= '0;
      rel <= '0;
    end else begin
      gap <= (sample_ready_n && !next_sample_ready_n) ? GAP_W'(1) : gap + GAP_W'(1);
      rel <= (&rel) ? rel : rel + REL_W'(1);
    end
  end

  a_strobe_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sample_ready_n && !next_sample_ready_n && state == ST_RUN) |-> gap == (GAP_W'(lvl) << DEC_LOG2))
    else $error("strobe period differs from 32 times level");

  a_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(sample_ready_n) && state == ST_RUN && sel_s != LVL_OFF) |=> !sample_ready_n)
    else $error("buffered strobe high longer than one clock");

  a_strobe_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(sample_ready_n_o) |-> $past(next_sample_ready_n))
    else $error("strobe rose without a clocked cause");

  a_bus_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (host_s.rd_n || host_s.cs_n) |=> !dout_oe_o)
    else $error("output bus driven while read or select high");

  a_reset_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sample_ready_n && !next_sample_ready_n && state == ST_FILL) |->
      rel == ((REL_W'(lvl) + REL_W'(1)) << DEC_LOG2) - REL_W'(1))
    else $error("first strobe fall not at 32 times level plus one");

  a_decim_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick |=> !tick [*8] ##24 tick)
    else $error("decimation tick not every 32 clocks");

  a_range_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && clip) |=> over_range_flag_o)
    else $error("out of range not flagged");

  a_sat_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && avg > $signed(POS_LIM)) |-> word == POS_FULL)
    else $error("positive overflow not saturated");

  a_read_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_rise && !group_done) |=> rd_ptr == $past(rd_ptr) + 4'h1)
    else $error("read pulse did not advance the word");

  c_unbuffered: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(sample_ready_n) && sel_s == LVL_OFF);
  c_buffered_max: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(sample_ready_n) && lvl == 3'h7);
  c_read_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_rise);
  c_over_range: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(over_range_flag_o));
endmodule // afrp_core

// file: afrp_word_store.sv
`timescale 1ns/1ps
module afrp_word_store import afrp_pkg::*; (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // write side
  input  wire logic              wr_en_i,
  input  wire logic [PTR_W-1:0]  wr_ptr_i,
  input  wire logic [WORD_W-1:0] wr_data_i,
  // read side
  input  wire logic [PTR_W-1:0]  rd_ptr_i,
  output logic [WORD_W-1:0]      rd_data_o
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];

  // one flop word per entry, written by index
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem[i] <= WORD_RST;
      end else if (wr_en_i && wr_ptr_i == PTR_W'(i)) begin
        mem[i] <= wr_data_i;
      end
    end
  end

  assign rd_data_o = mem[rd_ptr_i];
endmodule // afrp_word_store

// file: afrp_host_model.sv
`timescale 1ns/1ps
module afrp_host_model import afrp_pkg::*; (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // device pins
  input  wire logic              ready_n_i,
  input  wire logic              oe_i,
  input  wire logic [WORD_W-1:0] dout_i,
  input  wire logic [LVL_W-1:0]  level_i,
  // read pins and captured words
  output afrp_host_type          host_o,
  output logic                   got_o,
  output logic [WORD_W-1:0]      word_o
);
  logic prev_n;
  int   n_rd;

  // one group of reads after each strobe fall, idle pins high otherwise
  initial begin
    host_o = '{rd_n: 1'b1, cs_n: 1'b1};
    got_o = 1'b0;
    word_o = '0;
    prev_n = 1'b1;
    forever begin
      @(negedge clk_i);
      if (rst_n_i && prev_n && !ready_n_i) begin
        n_rd = (level_i == LVL_OFF) ? 1 : int'(level_i);
        repeat (n_rd) begin
          host_o = '{rd_n: 1'b0, cs_n: 1'b0};
          repeat (4) @(negedge clk_i);
          @(posedge clk_i);
          word_o <= oe_i ? dout_i : 'x; // undriven bus reads as unknown
          got_o <= 1'b1;
          @(posedge clk_i);
          got_o <= 1'b0;
          @(negedge clk_i);
          host_o = '{rd_n: 1'b1, cs_n: 1'b1};
          repeat (3) @(negedge clk_i);
        end
      end
      prev_n = ready_n_i;
    end
  end
endmodule // afrp_host_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top import afrp_pkg::*;;
  logic                       clk_i;
  logic                       rst_n_i;
  logic                       own;
  logic                       ready_n;
  logic                       over;
  logic                       oe;
  logic                       got;
  logic signed [SAMPLE_W-1:0] sample;
  logic [LVL_W-1:0]           level;
  logic [WORD_W-1:0]          dout;
  logic [WORD_W-1:0]          word;
  afrp_host_type              tb_host;
  afrp_host_type              m_host;
  int                         err_total;
  int                         n_compared;

  afrp_core dut (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .sample_i          (sample),
    .host_i            (own ? tb_host : m_host),
    .buffer_depth_sel_i(level),
    .sample_ready_n_o  (ready_n),
    .over_range_flag_o (over),
    .dout_o            (dout),
    .dout_oe_o         (oe)
  );

  afrp_host_model host (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .ready_n_i(ready_n),
    .oe_i     (oe),
    .dout_i   (dout),
    .level_i  (level),
    .host_o   (m_host),
    .got_o    (got),
    .word_o   (word)
  );

  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // reset with level and sample set, then release off the sampling edge
  task automatic do_reset(input logic [LVL_W-1:0] l, input logic [SAMPLE_W-1:0] v);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    level = l;
    sample = v;
    repeat (16) @(negedge clk_i);
    check({ready_n, oe, over, dout}, {1'b1, 1'b0, 1'b0, WORD_RST});
    rst_n_i = 1'b1;
  endtask

  // strobe timing and one group of words at a given level
  task automatic run_group(input logic [LVL_W-1:0] l, input logic [SAMPLE_W-1:0] v,
                           input logic [WORD_W-1:0] ew, input logic ef);
    int t, f1, f2, hi, nw;
    logic prev;
    do_reset(l, v);
    t = 0;
    f1 = 0;
    f2 = 0;
    hi = 0;
    nw = 0;
    prev = 1'b1;
    while (f2 == 0 && t < 2000) begin
      @(negedge clk_i);
      t++;
      if (prev && !ready_n) begin
        if (f1 == 0) f1 = t;
        else f2 = t;
      end
      if (f1 != 0 && f2 == 0 && ready_n) hi++;
      if (got && f2 == 0) begin
        nw++;
        check(word, ew);
        check(over, ef);
      end
      prev = ready_n;
    end
    check(f1, (l == 0) ? 64 : 32 * (l + 1));
    check(f2 - f1, (l == 0) ? 32 : 32 * l);
    check(hi, (l == 0) ? 16 : 1);
    check(nw, (l == 0) ? 1 : l);
    repeat (80) @(negedge clk_i);
  endtask

  // a new word per decimation window: a group must come out oldest first
  task automatic read_order;
    int t, k;
    do_reset(3'h3, 20'h00000);
    k = 0;
    for (t = 1; t <= 300; t++) begin
      @(negedge clk_i);
      if (t % 32 == 0) sample = 20'(t * 8);
      if (got && k < 3) begin
        k++;
        check(word, 18'(k * 256));
      end
    end
    check(k, 3);
  endtask

  // the bus is driven only while read and select are both low
  task automatic select_gate;
    int i;
    do_reset(3'h1, 20'h00100);
    own = 1'b1;
    repeat (100) @(negedge clk_i);
    tb_host = '{rd_n: 1'b0, cs_n: 1'b1};
    for (i = 0; i < 8; i++) begin
      @(negedge clk_i);
      check(oe, 1'b0);
    end
    tb_host = '{rd_n: 1'b1, cs_n: 1'b0};
    repeat (4) @(negedge clk_i);
    check(oe, 1'b0);
    tb_host.rd_n = 1'b0;
    repeat (2) @(negedge clk_i);
    check(oe, 1'b0);
    repeat (2) @(negedge clk_i);
    check(oe, 1'b1);
    check(dout, 18'h00100);
    tb_host = '{rd_n: 1'b1, cs_n: 1'b1};
    repeat (4) @(negedge clk_i);
    check(oe, 1'b0);
    own = 1'b0;
  endtask

  // watchdog
  initial begin
    #(20 * 20000);
    err_total++;
    results();
  end

  // main sequence
  initial begin
    int l;
    err_total = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    own = 1'b0;
    tb_host = '{rd_n: 1'b1, cs_n: 1'b1};
    level = 3'h0;
    sample = 20'h00000;
    for (l = 0; l < 8; l++) begin
      run_group(3'(l), 20'h00A5C + 20'(l * 256), 18'h00A5C + 18'(l * 256), 1'b0);
    end
    run_group(3'h2, 20'hFFF00, 18'h3FF00, 1'b0);
    run_group(3'h1, 20'h3FFFF, POS_FULL, 1'b1);
    run_group(3'h1, 20'hC0000, NEG_FULL, 1'b1);
    read_order();
    select_gate();
    results();
  end
endmodule // tb_top
